// ===== rtl/ufb_pkg.sv
// Constants shared by the frame format and baud rate configuration slice.
// Assumes a 32-bit AXI4-Lite register bus and a 50 MHz system clock.
package ufb_pkg;

	// ==========================================================
	// Register map (byte addresses, one aligned word each)
	localparam logic [7:0] UFB_ADDR_STATUS_A = 8'h00;
	localparam logic [7:0] UFB_ADDR_LINE_B = 8'h04;
	localparam logic [7:0] UFB_ADDR_FRAME = 8'h08;
	localparam logic [7:0] UFB_ADDR_DIV_LOW = 8'h0c;
	localparam logic [7:0] UFB_ADDR_DIV_HIGH = 8'h10;

	// ==========================================================
	// Reset values and writable masks
	localparam logic [7:0] UFB_RST_STATUS_A = 8'h00;
	localparam logic [7:0] UFB_RST_LINE_B = 8'h00;
	localparam logic [7:0] UFB_RST_FRAME = 8'h06;
	localparam logic [7:0] UFB_RST_DIV = 8'h00;
	localparam logic [7:0] UFB_MASK_STATUS_A = 8'h02;
	localparam logic [7:0] UFB_MASK_LINE_B = 8'hfd;
	localparam logic [7:0] UFB_MASK_FRAME = 8'h7f;
	localparam logic [7:0] UFB_MASK_DIV_HIGH = 8'h0f;

	// ==========================================================
	// Field positions
	localparam int UFB_BIT_DOUBLE_SPEED = 1;
	localparam int UFB_BIT_CHAR_SIZE_MSB = 2;
	localparam int UFB_BIT_RX_NINTH = 1;
	localparam int UFB_BIT_TX_NINTH = 0;
	localparam int UFB_BIT_SYNC_SELECT = 6;
	localparam int UFB_BIT_PARITY_HI = 5;
	localparam int UFB_BIT_PARITY_LO = 4;
	localparam int UFB_BIT_STOP = 3;
	localparam int UFB_BIT_SIZE_HI = 2;
	localparam int UFB_BIT_SIZE_LO = 1;
	localparam int UFB_BIT_POLARITY = 0;

	// ==========================================================
	// Character size codes and data bit counts
	localparam logic [2:0] UFB_CS_5 = 3'h0;
	localparam logic [2:0] UFB_CS_6 = 3'h1;
	localparam logic [2:0] UFB_CS_7 = 3'h2;
	localparam logic [2:0] UFB_CS_8 = 3'h3;
	localparam logic [2:0] UFB_CS_9 = 3'h7;
	localparam logic [3:0] UFB_BITS_5 = 4'h5;
	localparam logic [3:0] UFB_BITS_6 = 4'h6;
	localparam logic [3:0] UFB_BITS_7 = 4'h7;
	localparam logic [3:0] UFB_BITS_8 = 4'h8;
	localparam logic [3:0] UFB_BITS_9 = 4'h9;
	localparam logic [3:0] UFB_BITS_NONE = 4'h0;

	// ==========================================================
	// Baud divider ratios (in prescaler ticks) and widths
	localparam int UFB_DIV_W = 12;
	localparam logic [3:0] UFB_PHASE_NORMAL_LAST = 4'hf;
	localparam logic [3:0] UFB_PHASE_DOUBLE_LAST = 4'h7;

	// ==========================================================
	// AXI responses
	localparam logic [1:0] UFB_RESP_OKAY = 2'h0;
	localparam logic [1:0] UFB_RESP_SLVERR = 2'h2;

endpackage : ufb_pkg

// ===== rtl/ufb_baud_prescaler.sv
// 12-bit down-counting baud prescaler, one tick per divisor+1 clocks.
// Assumes the reload strobe is a single-cycle pulse from the register file.
`timescale 1ns/10ps
`default_nettype none
module ufb_baud_prescaler import ufb_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic reload_i,
	input wire logic [UFB_DIV_W-1:0] divisor_i,
	output logic tick_o
);
	logic [UFB_DIV_W-1:0] cnt_reg;
	logic [UFB_DIV_W-1:0] cnt_next;

	// ==========================================================
	// Counter: reload wins over the natural wrap, no frame awareness
	always_comb begin
		if (reload_i) begin
			cnt_next = divisor_i;
		end else if (cnt_reg == '0) begin
			cnt_next = divisor_i;
		end else begin
			cnt_next = cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// Tick suppressed in the reload cycle so a new rate starts cleanly
	assign tick_o = (cnt_reg == '0) && !reload_i;

	// ==========================================================
	// Checks
	reload_loads_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		reload_i |=> cnt_reg == $past(divisor_i))
		else $error("prescaler did not load divisor on reload");
	tick_period_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		tick_o && !reload_i ##1 (!reload_i && $stable(divisor_i) && cnt_reg != '0)
		|-> !tick_o)
		else $error("prescaler ticked before count ran out");
endmodule : ufb_baud_prescaler
`default_nettype wire

// ===== rtl/ufb_frame_baud_cfg.sv
// Frame format and baud rate configuration slice of a serial transceiver.
// Assumes an AXI4-Lite master and shifters that consume the strobes below.
//
// How it works
// - Size field 000..011 gives 5..8 bits, 111 gives 9, rest reserved.
// - Sync polarity 0: transmit changes on rising, sample on falling clock.
// - Divisor is 12 bits: high byte low nibble, then low byte.
// - A low byte write takes effect at once, even mid frame; a high byte write alone waits for the next prescaler wrap.
// - Low byte write reloads prescaler; high byte write alone does not.
// - Divisor zero gives oscillator/16 in asynchronous mode, or /8 in double speed; in sync mode the serial clock is oscillator/2.
// - Double speed in asynchronous mode divides by 8 instead of 16.
`timescale 1ns/10ps
`default_nettype none
module ufb_frame_baud_cfg import ufb_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rx_ninth_bit_i,
	output logic [3:0] char_bits_o,
	output logic char_size_reserved_o,
	output logic sync_mode_o,
	output logic [1:0] parity_mode_o,
	output logic two_stop_o,
	output logic double_speed_o,
	output logic tx_ninth_bit_o,
	output logic bit_tick_o,
	output logic sample_tick_o,
	output logic tx_change_o,
	output logic rx_sample_o,
	output logic sync_serial_clock_o
);
	logic [7:0] status_a_reg, status_a_next;
	logic [7:0] line_b_reg, line_b_next;
	logic [7:0] frame_reg, frame_next;
	logic [7:0] div_low_reg, div_low_next;
	logic [7:0] div_high_reg, div_high_next;
	logic aw_held_reg, aw_held_next;
	logic w_held_reg, w_held_next;
	logic [7:0] awaddr_reg, awaddr_next;
	logic [7:0] wdata_reg, wdata_next;
	logic wstrb0_reg, wstrb0_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [3:0] phase_reg, phase_next;
	logic sclk_reg, sclk_next;
	logic wr_fire, rd_fire, wr_mapped, rd_mapped, low_wr, presc_tick;
	logic [2:0] size_code;
	logic [3:0] phase_last;
	logic [11:0] divisor;
	logic [7:0] rd_word;

	// ==========================================================
	// Write channel: address and data taken in either order
	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready = !w_held_reg && !bvalid_reg;
	assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
	assign wr_mapped = (awaddr_reg == UFB_ADDR_STATUS_A) || (awaddr_reg == UFB_ADDR_LINE_B)
		|| (awaddr_reg == UFB_ADDR_FRAME) || (awaddr_reg == UFB_ADDR_DIV_LOW)
		|| (awaddr_reg == UFB_ADDR_DIV_HIGH);

	always_comb begin
		aw_held_next = aw_held_reg;
		w_held_next = w_held_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		wstrb0_next = wstrb0_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_next = 1'b1;
			awaddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_next = 1'b1;
			wdata_next = s_axi_wdata[7:0];
			wstrb0_next = s_axi_wstrb[0];
		end
		if (wr_fire) begin
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = wr_mapped ? UFB_RESP_OKAY : UFB_RESP_SLVERR;
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 8'h00;
			wstrb0_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= UFB_RESP_OKAY;
		end else begin
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb0_reg <= wstrb0_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	// ==========================================================
	// Register file; only byte lane 0 carries data
	always_comb begin
		status_a_next = status_a_reg;
		line_b_next = line_b_reg;
		frame_next = frame_reg;
		div_low_next = div_low_reg;
		div_high_next = div_high_reg;
		if (wr_fire && wstrb0_reg) begin
			case (awaddr_reg)
				UFB_ADDR_STATUS_A: status_a_next = wdata_reg & UFB_MASK_STATUS_A;
				UFB_ADDR_LINE_B: line_b_next = wdata_reg & UFB_MASK_LINE_B;
				UFB_ADDR_FRAME: frame_next = wdata_reg & UFB_MASK_FRAME;
				UFB_ADDR_DIV_LOW: div_low_next = wdata_reg;
				UFB_ADDR_DIV_HIGH: div_high_next = wdata_reg & UFB_MASK_DIV_HIGH;
				default: status_a_next = status_a_reg;
			endcase
		end
	end

	// Divisor bytes clear at reset
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			status_a_reg <= UFB_RST_STATUS_A;
			line_b_reg <= UFB_RST_LINE_B;
			frame_reg <= UFB_RST_FRAME;
			div_low_reg <= UFB_RST_DIV;
			div_high_reg <= UFB_RST_DIV;
		end else begin
			status_a_reg <= status_a_next;
			line_b_reg <= line_b_next;
			frame_reg <= frame_next;
			div_low_reg <= div_low_next;
			div_high_reg <= div_high_next;
		end
	end

	// ==========================================================
	// Read channel, data registered; unmapped reads answer SLVERR
	assign s_axi_arready = !rvalid_reg;
	assign rd_fire = s_axi_arvalid && !rvalid_reg;

	always_comb begin
		rd_mapped = 1'b1;
		case (s_axi_araddr)
			UFB_ADDR_STATUS_A: rd_word = status_a_reg;
			UFB_ADDR_LINE_B: rd_word = {line_b_reg[7:2], rx_ninth_bit_i, line_b_reg[0]};
			UFB_ADDR_FRAME: rd_word = frame_reg;
			UFB_ADDR_DIV_LOW: rd_word = div_low_reg;
			UFB_ADDR_DIV_HIGH: rd_word = div_high_reg & UFB_MASK_DIV_HIGH;
			default: begin
				rd_word = 8'h00;
				rd_mapped = 1'b0;
			end
		endcase
	end

	always_comb begin
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (rd_fire) begin
			rvalid_next = 1'b1;
			rdata_next = rd_word;
			rresp_next = rd_mapped ? UFB_RESP_OKAY : UFB_RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 8'h00;
			rresp_reg <= UFB_RESP_OKAY;
		end else begin
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = {24'h000000, rdata_reg};
	assign s_axi_rresp = rresp_reg;

	// ==========================================================
	// Frame format decode, shared by receiver and transmitter
	assign size_code = {line_b_reg[UFB_BIT_CHAR_SIZE_MSB],
		frame_reg[UFB_BIT_SIZE_HI:UFB_BIT_SIZE_LO]};

	always_comb begin
		char_size_reserved_o = 1'b0;
		case (size_code)
			UFB_CS_5: char_bits_o = UFB_BITS_5;
			UFB_CS_6: char_bits_o = UFB_BITS_6;
			UFB_CS_7: char_bits_o = UFB_BITS_7;
			UFB_CS_8: char_bits_o = UFB_BITS_8;
			UFB_CS_9: char_bits_o = UFB_BITS_9;
			default: begin
				char_bits_o = UFB_BITS_NONE;
				char_size_reserved_o = 1'b1;
			end
		endcase
	end

	assign sync_mode_o = frame_reg[UFB_BIT_SYNC_SELECT];
	assign parity_mode_o = frame_reg[UFB_BIT_PARITY_HI:UFB_BIT_PARITY_LO];
	assign two_stop_o = frame_reg[UFB_BIT_STOP];
	assign tx_ninth_bit_o = line_b_reg[UFB_BIT_TX_NINTH];
	// Double speed is meaningless in synchronous mode, so it is gated off
	assign double_speed_o = status_a_reg[UFB_BIT_DOUBLE_SPEED] && !sync_mode_o;

	// ==========================================================
	// Baud generation: prescaler reload on low byte write only
	assign divisor = {div_high_reg[3:0], div_low_reg};
	assign low_wr = wr_fire && wstrb0_reg && (awaddr_reg == UFB_ADDR_DIV_LOW);

	ufb_baud_prescaler u_presc (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.reload_i(low_wr),
		// Reload takes the byte being stored; a natural wrap uses the held divisor
		.divisor_i(low_wr ? {div_high_reg[3:0], wdata_reg} : divisor),
		.tick_o(presc_tick)
	);

	assign phase_last = double_speed_o ? UFB_PHASE_DOUBLE_LAST : UFB_PHASE_NORMAL_LAST;

	// Phase restarts on reload; frames in flight are not protected
	always_comb begin
		phase_next = phase_reg;
		sclk_next = sclk_reg;
		if (low_wr) begin
			phase_next = 4'h0;
			sclk_next = 1'b0;
		end else if (presc_tick) begin
			phase_next = (phase_reg >= phase_last) ? 4'h0 : phase_reg + 4'h1;
			sclk_next = sync_mode_o ? !sclk_reg : 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			phase_reg <= 4'h0;
			sclk_reg <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			sclk_reg <= sclk_next;
		end
	end

	// Async: one bit per 16 or 8 ticks; sync: one bit per clock period
	assign sample_tick_o = presc_tick && !sync_mode_o;
	assign bit_tick_o = sample_tick_o && (phase_reg >= phase_last);
	assign sync_serial_clock_o = sclk_reg;
	// Polarity picks which clock edge drives and which samples
	always_comb begin
		if (!sync_mode_o) begin
			tx_change_o = bit_tick_o;
			rx_sample_o = 1'b0;
		end else if (!frame_reg[UFB_BIT_POLARITY]) begin
			tx_change_o = presc_tick && !sclk_reg;
			rx_sample_o = presc_tick && sclk_reg;
		end else begin
			tx_change_o = presc_tick && sclk_reg;
			rx_sample_o = presc_tick && !sclk_reg;
		end
	end

	// ==========================================================
	// Checks
	size_eight_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		size_code == UFB_CS_8 |-> char_bits_o == UFB_BITS_8 && !char_size_reserved_o)
		else $error("size code 011 not decoded as 8 bits");
	size_reserved_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		size_code[2] && size_code != UFB_CS_9 |-> char_size_reserved_o)
		else $error("reserved size code not flagged");
	sync_pol_edges_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		sync_mode_o && !frame_reg[UFB_BIT_POLARITY] && tx_change_o && !low_wr
		|=> $rose(sync_serial_clock_o))
		else $error("transmit change not on rising serial clock");
	div_high_read_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		rd_fire && s_axi_araddr == UFB_ADDR_DIV_HIGH |=> s_axi_rdata[7:4] == 4'h0)
		else $error("reserved divisor bits read nonzero");
	high_no_reload_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		wr_fire && awaddr_reg == UFB_ADDR_DIV_HIGH && !presc_tick
		|=> phase_reg == $past(phase_reg))
		else $error("high byte write disturbed the baud phase");
	low_reload_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		low_wr |=> phase_reg == 4'h0 && !sync_serial_clock_o)
		else $error("low byte write did not restart the baud divider");
	// Back-to-back prescaler ticks since the last bit tick; a write or a gap restarts it,
	// so a high byte write that leaves an old count running cannot trip the rate checks
	logic [3:0] rate_gap_reg, rate_gap_next;
	always_comb begin
		rate_gap_next = (bit_tick_o || wr_fire || !presc_tick) ? 4'h0 : rate_gap_reg + 4'h1;
	end
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rate_gap_reg <= 4'h0;
		end else begin
			rate_gap_reg <= rate_gap_next;
		end
	end
	div_zero_normal_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		presc_tick && divisor == '0 && !sync_mode_o && !double_speed_o
		&& rate_gap_reg == UFB_PHASE_NORMAL_LAST |-> bit_tick_o)
		else $error("divisor zero did not give clock/16");
	div_zero_double_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		presc_tick && divisor == '0 && !sync_mode_o && double_speed_o
		&& rate_gap_reg == UFB_PHASE_DOUBLE_LAST |-> bit_tick_o)
		else $error("double speed did not give clock/8");
	reset_div_a: assert property (@(posedge sys_clk_i)
		$rose(rst_b_i) |-> divisor == '0)
		else $error("divisor not cleared by reset");

	sync_mode_c: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		sync_mode_o && rx_sample_o);
	nine_bit_c: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		char_bits_o == UFB_BITS_9);
	double_speed_c: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		double_speed_o && bit_tick_o);
	reload_c: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) low_wr);
endmodule : ufb_frame_baud_cfg
`default_nettype wire

// ===== testbench/ufb_line_peer.sv
// Far-side line peer: times the bit strobes and the synchronous serial clock.
// Assumes single-cycle strobes from the configuration slice, system clock only.
`timescale 1ns/10ps
`default_nettype none
module ufb_line_peer (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic bit_tick_i,
	input wire logic sync_clk_i,
	input wire logic tx_change_i,
	input wire logic rx_sample_i,
	output logic [15:0] bit_gap_o,
	output logic [15:0] clk_gap_o,
	output logic chg_lvl_o,
	output logic smp_lvl_o
);
	// ==========================================================
	// Gap and edge measurement
	logic [15:0] bit_cnt_reg;
	logic [15:0] clk_cnt_reg;
	logic sclk_reg;
	logic chg_reg;
	logic smp_reg;

	// Measures the link as a remote receiver locking to it would
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bit_cnt_reg <= 16'h0001;
			clk_cnt_reg <= 16'h0001;
			sclk_reg <= 1'b0;
			chg_reg <= 1'b0;
			smp_reg <= 1'b0;
			bit_gap_o <= 16'h0000;
			clk_gap_o <= 16'h0000;
			chg_lvl_o <= 1'b0;
			smp_lvl_o <= 1'b0;
		end else begin
			bit_cnt_reg <= bit_tick_i ? 16'h0001 : bit_cnt_reg + 16'h0001;
			if (bit_tick_i) bit_gap_o <= bit_cnt_reg;
			sclk_reg <= sync_clk_i;
			clk_cnt_reg <= (sync_clk_i && !sclk_reg) ? 16'h0001 : clk_cnt_reg + 16'h0001;
			if (sync_clk_i && !sclk_reg) clk_gap_o <= clk_cnt_reg;
			chg_reg <= tx_change_i;
			smp_reg <= rx_sample_i;
			// Level after a strobe tells which clock edge it led
			if (chg_reg) chg_lvl_o <= sync_clk_i;
			if (smp_reg) smp_lvl_o <= sync_clk_i;
		end
	end
endmodule : ufb_line_peer
`default_nettype wire

// ===== testbench/tb_usart_frame_baud_config.sv
// Self-checking bench for the frame format and baud configuration slice.
// Assumes an AXI4-Lite master here and the line peer on the strobe outputs.
`timescale 1ns/10ps
`default_nettype none
module tb_usart_frame_baud_config import ufb_pkg::*;;
	logic sys_clk_i, rst_b_i, awvalid, wvalid, bvalid, bready, awready, wready;
	logic arvalid, arready, rvalid, rready, rx_ninth, rsv, sync_m, dbl, tx9;
	logic btick, stick, chg, smp, sclk, two_stop;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp, par;
	logic [3:0] cbits;
	logic [15:0] bit_gap, clk_gap;
	logic chg_lvl, smp_lvl;
	logic [7:0] rows [8];
	int error_cnt, n_tests, k;

	ufb_frame_baud_cfg dut_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.rx_ninth_bit_i(rx_ninth), .char_bits_o(cbits), .char_size_reserved_o(rsv),
		.sync_mode_o(sync_m), .parity_mode_o(par), .two_stop_o(two_stop),
		.double_speed_o(dbl), .tx_ninth_bit_o(tx9), .bit_tick_o(btick),
		.sample_tick_o(stick), .tx_change_o(chg), .rx_sample_o(smp),
		.sync_serial_clock_o(sclk));

	ufb_line_peer peer_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .bit_tick_i(btick),
		.sync_clk_i(sclk), .tx_change_i(chg), .rx_sample_i(smp), .bit_gap_o(bit_gap),
		.clk_gap_o(clk_gap), .chg_lvl_o(chg_lvl), .smp_lvl_o(smp_lvl));

	// ==========================================================
	// Clock and report helpers
	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end

	task automatic close_out;
		if (error_cnt == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// ==========================================================
	// Bus tasks: entered just after a rising edge; ready sampled at the
	// falling edge, since it only moves at rising edges
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ha, hw, hb, done;
		logic [1:0] r;
		int i;
		done = 1'b0;
		// One idle edge between calls, so no signal is set twice at once
		@(posedge sys_clk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 40 && !done; i++) begin
			@(negedge sys_clk_i);
			ha = awvalid && awready;
			hw = wvalid && wready;
			hb = bready && bvalid;
			r = bresp;
			@(posedge sys_clk_i);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			if (hb) begin
				bready <= 1'b0;
				done = 1'b1;
				chk("bresp", {30'h0, r}, {30'h0, er});
			end
		end
		if (!done) begin
			error_cnt++;
			close_out();
		end
	endtask : axw

	task automatic rdchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ha, hr, done;
		logic [31:0] d;
		logic [1:0] r;
		int i;
		done = 1'b0;
		@(posedge sys_clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 40 && !done; i++) begin
			@(negedge sys_clk_i);
			ha = arvalid && arready;
			hr = rready && rvalid;
			d = rdata;
			r = rresp;
			@(posedge sys_clk_i);
			if (ha) arvalid <= 1'b0;
			if (hr) begin
				rready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done) begin
			error_cnt++;
			close_out();
		end else begin
			chk("rdata", d, ed);
			chk("rresp", {30'h0, r}, {30'h0, er});
		end
	endtask : rdchk

	// Full divisor set, high byte first so the low write reloads with both
	task automatic baud(input logic [7:0] st, fr, hi, lo, input int w);
		axw(UFB_ADDR_STATUS_A, {24'h0, st}, UFB_RESP_OKAY);
		axw(UFB_ADDR_FRAME, {24'h0, fr}, UFB_RESP_OKAY);
		axw(UFB_ADDR_DIV_HIGH, {24'h0, hi}, UFB_RESP_OKAY);
		axw(UFB_ADDR_DIV_LOW, {24'h0, lo}, UFB_RESP_OKAY);
		repeat (w) @(posedge sys_clk_i);
	endtask : baud

	// ==========================================================
	// Main sequence
	initial begin
		// Rows: size msb, size low bits, data bits, reserved flag
		rows = '{8'h0a, 8'h2c, 8'h4e, 8'h70, 8'h81, 8'ha1, 8'hc1, 8'hf2};
		error_cnt = 0;
		n_tests = 0;
		rst_b_i = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, rx_ninth} = 6'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		repeat (3) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		@(posedge sys_clk_i);
		rdchk(UFB_ADDR_FRAME, 32'h06, UFB_RESP_OKAY);
		chk("char_bits", {28'h0, cbits}, 32'h8);
		rdchk(UFB_ADDR_DIV_HIGH, 32'h0, UFB_RESP_OKAY);
		rdchk(UFB_ADDR_DIV_LOW, 32'h0, UFB_RESP_OKAY);
		for (k = 0; k < 8; k++) begin
			axw(UFB_ADDR_LINE_B, {29'h0, rows[k][7], 2'h0}, UFB_RESP_OKAY);
			axw(UFB_ADDR_FRAME, {29'h0, rows[k][6:5], 1'b0}, UFB_RESP_OKAY);
			chk("char_bits", {28'h0, cbits}, {28'h0, rows[k][4:1]});
			chk("size_rsv", {31'h0, rsv}, {31'h0, rows[k][0]});
		end
		axw(UFB_ADDR_LINE_B, 32'h0, UFB_RESP_OKAY);
		// Parity, stop and mode fields pass straight out; bit 7 reads zero
		axw(UFB_ADDR_FRAME, 32'hbe, UFB_RESP_OKAY);
		rdchk(UFB_ADDR_FRAME, 32'h3e, UFB_RESP_OKAY);
		chk("parity", {30'h0, par}, 32'h3);
		chk("two_stop", {31'h0, two_stop}, 32'h1);
		chk("sync_off", {31'h0, sync_m}, 32'h0);
		// Upper nibble of the high byte stays zero whatever is written
		axw(UFB_ADDR_DIV_HIGH, 32'hff, UFB_RESP_OKAY);
		rdchk(UFB_ADDR_DIV_HIGH, 32'h0f, UFB_RESP_OKAY);
		axw(UFB_ADDR_DIV_HIGH, 32'h0, UFB_RESP_OKAY);
		axw(8'h14, 32'h5, UFB_RESP_SLVERR);
		rdchk(8'h14, 32'h0, UFB_RESP_SLVERR);
		// Ninth bits: received one read back, transmit one driven out
		rx_ninth <= 1'b1;
		axw(UFB_ADDR_LINE_B, 32'h1, UFB_RESP_OKAY);
		chk("tx_ninth", {31'h0, tx9}, 32'h1);
		rdchk(UFB_ADDR_LINE_B, 32'h3, UFB_RESP_OKAY);
		rx_ninth <= 1'b0;
		// Asynchronous rates, polarity kept zero outside sync mode
		baud(8'h00, 8'h06, 8'h00, 8'h03, 300);
		chk("gap_div3", {16'h0, bit_gap}, 32'd64);
		baud(8'h00, 8'h06, 8'h00, 8'h00, 100);
		chk("gap_div0", {16'h0, bit_gap}, 32'd16);
		chk("stick_async", {31'h0, stick}, 32'h1);
		baud(8'h02, 8'h06, 8'h00, 8'h00, 100);
		chk("gap_dbl", {16'h0, bit_gap}, 32'd8);
		baud(8'h00, 8'h06, 8'h01, 8'h00, 13000);
		chk("gap_256", {16'h0, bit_gap}, 32'd4112);
		// Slow rate running: a low write must switch at once
		baud(8'h00, 8'h06, 8'h00, 8'h00, 60);
		chk("gap_reload", {16'h0, bit_gap}, 32'd16);
		// Synchronous clock, both polarities
		baud(8'h00, 8'h40, 8'h00, 8'h01, 40);
		chk("sclk_gap", {16'h0, clk_gap}, 32'd4);
		chk("sync_on", {31'h0, sync_m}, 32'h1);
		chk("stick_sync", {31'h0, stick}, 32'h0);
		chk("chg_lvl0", {31'h0, chg_lvl}, 32'h1);
		chk("smp_lvl0", {31'h0, smp_lvl}, 32'h0);
		baud(8'h02, 8'h41, 8'h00, 8'h01, 40);
		chk("chg_lvl1", {31'h0, chg_lvl}, 32'h0);
		chk("smp_lvl1", {31'h0, smp_lvl}, 32'h1);
		chk("dbl_sync", {31'h0, dbl}, 32'h0);
		axw(UFB_ADDR_FRAME, 32'h06, UFB_RESP_OKAY);
		// Reset in mid-run clears the divisor again
		rst_b_i <= 1'b0;
		@(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		@(posedge sys_clk_i);
		rdchk(UFB_ADDR_DIV_LOW, 32'h0, UFB_RESP_OKAY);
		chk("dbl_reset", {31'h0, dbl}, 32'h0);
		close_out();
	end
endmodule : tb_usart_frame_baud_config
`default_nettype wire
